// File: inc/mic_consts.svh
// Constants of the interrupt controller: register offsets, field positions, reset values.
// Assumes inclusion by bare name from the core files and the testbench.
// What this block does
// - Nine maskable sources, each with a request latch and enable bit, in two bytes.
// - External inputs trigger on rising, falling or both edges, chosen per pin.
// - Vectoring to an external source clears its edge request flag.
// - Timer 0 and timer 1 flags set on compare match.
// - Interval timer flag sets on counter overflow.
// - Converter flag sets on conversion done; watchdog flag on watchdog match.
// - A request reaches the core only with flag, enable and global enable set.
// - Fixed priority external a, external b, timer 0, timer 1, converter, watchdog, interval, serial.
// - A disabled source is never accepted though its flag may set.
// - Disable instruction clears global enable, enable instruction sets it.
// - Return from interrupt sets global enable again.
// - A flag holds until accepted, reset or cleared by software.
// - Acceptance takes eight oscillator periods after the current instruction.
// - Accept order: clear global enable, clear flag, three pushes, load vector.
// - With global enable clear no maskable request is accepted, even higher priority.
// - Software break is lowest priority, shares table call zero vector, sets break flag.
// - Simultaneous requests resolve to the higher priority one.
// - External edges are sampled each machine cycle and evaluated the next.
// - An external request waits for two sync flops, the next machine-cycle sample and an instruction end before service starts.
// - Serial flag sets when a transfer completes with the clock halted high.
`ifndef MIC_CONSTS_SVH
`define MIC_CONSTS_SVH
`define MIC_OFS_ENH      12'h0e2
`define MIC_OFS_ENL      12'h0e3
`define MIC_OFS_REQH     12'h0e4
`define MIC_OFS_REQL     12'h0e5
`define MIC_OFS_EDGE     12'h0f8
`define MIC_OFS_STAT     12'h0f0
`define MIC_OFS_CPU      12'h0f1
`define MIC_RST_BYTE     8'h00
`define MIC_NSRC         9
`define MIC_SRC_BRK      4'h9
`define MIC_VEC_BASE     16'hffe0
`define MIC_VEC_BRK      16'hffde
`define MIC_ACC_CYC      4'h8
`define MIC_MC_DIV       4'h4
`define MIC_PUSHES       2'h3
`define MIC_PSW_I        2
`define MIC_PSW_B        4
`define MIC_EDGE_RISE    2'h1
`define MIC_EDGE_FALL    2'h2
`define MIC_EDGE_BOTH    2'h3
`endif

// File: inc/mic_pkg.sv
// Types shared by the interrupt controller files.
// Assumes the constants header sits beside it.
package mic_pkg;
	typedef enum logic [2:0] {
		MIC_IDLE,
		MIC_CLR_I,
		MIC_CLR_F,
		MIC_PUSH,
		MIC_VEC,
		MIC_WAIT
	} mic_state_t;
endpackage

// File: inc/mic_edge_if.sv
// Carrier between the core and its edge detector.
// Assumes one clock domain; pins are already synchronised.
`timescale 1ns/100ps
interface mic_edge_if;
	logic [1:0] pin;
	logic [3:0] mode;
	logic       mc_en;
	logic [1:0] hit;
	modport core (output pin, output mode, output mc_en, input hit);
	modport det  (input pin, input mode, input mc_en, output hit);
endinterface

// File: core/mic_edge_det.sv
// Edge detector for the two external interrupt inputs.
// Assumes synchronised pin levels and a machine-cycle enable pulse.
`timescale 1ns/100ps
`include "mic_consts.svh"
module mic_edge_det
	import mic_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	mic_edge_if.det   e
);
	logic [1:0] last_r;
	logic [1:0] rise;
	logic [1:0] fall;

	// Edges judged once a machine cycle, so short glitches between samples are missed
	assign rise = e.pin & ~last_r;
	assign fall = ~e.pin & last_r;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			assign e.hit[g] = e.mc_en & (
				((e.mode[2*g+:2] == `MIC_EDGE_RISE) & rise[g]) |
				((e.mode[2*g+:2] == `MIC_EDGE_FALL) & fall[g]) |
				((e.mode[2*g+:2] == `MIC_EDGE_BOTH) & (rise[g] | fall[g])));
		end
	endgenerate

	// Sample memory advances only on the machine-cycle pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			last_r <= 2'h0;
		end else if (e.mc_en) begin
			last_r <= e.pin;
		end
	end
endmodule // mic_edge_det

// File: core/mic_intc.sv
// Interrupt controller core: request flags, enables, priority, acceptance sequence.
// Assumes a core sequencer that pulses instruction events and follows the accept strobes.
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/100ps
`include "mic_consts.svh"
module mic_intc
	import mic_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [11:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        external_irq_a,
	input  wire logic        external_irq_b,
	input  wire logic        timer0_match,
	input  wire logic        timer1_match,
	input  wire logic        conversion_done,
	input  wire logic        watchdog_match,
	input  wire logic        interval_overflow,
	input  wire logic        serial_done,
	input  wire logic        instr_done,
	input  wire logic        disable_irq_instr,
	input  wire logic        enable_irq_instr,
	input  wire logic        return_from_irq,
	input  wire logic        software_break,
	output logic             irq_to_cpu,
	output logic             acc_busy,
	output logic             push_strobe,
	output logic             vector_load,
	output logic      [15:0] vector_addr,
	output logic             break_flag,
	output logic             global_enable
);
	logic [1:0] rs_r;
	logic       rst_n;
	logic [1:0] pa_r;
	logic [1:0] pb_r;
	logic [8:0] req_r;
	logic [8:0] en_r;
	logic [7:0] edge_r;
	logic       gie_r;
	logic       brk_r;
	logic       brkp_r;
	logic [3:0] src_r;
	logic [3:0] cnt_r;
	logic [1:0] push_r;
	logic [3:0] mc_r;
	logic [15:0] vec_r;
	logic [31:0] rdata_r;
	logic       ack_r;
	mic_state_t st_r;
	mic_state_t st_nxt;
	mic_edge_if ed();

	// Reset released through two flops so release is clean to clk
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rs_r <= 2'h0;
		end else begin
			rs_r <= {rs_r[0], 1'b1};
		end
	end
	assign rst_n = rs_r[1];

	// Pins come from outside; two flops before anything looks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pa_r <= 2'h0;
			pb_r <= 2'h0;
		end else begin
			pa_r <= {pa_r[0], external_irq_a};
			pb_r <= {pb_r[0], external_irq_b};
		end
	end

	// Machine cycle pulse from divider
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mc_r <= 4'h0;
		end else begin
			mc_r <= (mc_r == `MIC_MC_DIV - 4'h1) ? 4'h0 : mc_r + 4'h1;
		end
	end

	assign ed.pin   = {pb_r[1], pa_r[1]};
	assign ed.mode  = edge_r[3:0];
	assign ed.mc_en = (mc_r == 4'h0);
	mic_edge_det u_edge (
		.clk   (clk),
		.rst_n (rst_n),
		.e     (ed.det)
	);

	// Priority pick: lowest index wins, index 9 means none
	function automatic logic [3:0] pick(input logic [8:0] v);
		pick = `MIC_SRC_BRK;
		for (int i = 8; i >= 0; i--) begin
			if (v[i]) begin
				pick = 4'(i);
			end
		end
	endfunction

	function automatic logic [15:0] vec_of(input logic [3:0] s);
		vec_of = (s == `MIC_SRC_BRK) ? `MIC_VEC_BRK : `MIC_VEC_BASE + 16'({s, 1'b0});
	endfunction

	logic [8:0] set_v;
	logic [8:0] live;
	logic [3:0] win;
	logic       start;
	logic       wr_hit;
	logic       rd_hit;
	logic       acc;
	logic [8:0] hw_clr;

	// Bit 0 external a .. bit 7 serial, bit 8 spare timer slot; index is priority
	assign set_v = {1'b0, serial_done, interval_overflow, watchdog_match,
		conversion_done, timer1_match, timer0_match, ed.hit};
	assign live  = req_r & en_r & {9{gie_r}};
	assign win   = pick(live);
	assign irq_to_cpu = |live;
	// Break has lowest priority, maskable sources are served first
	assign start = instr_done & (st_r == MIC_IDLE) & (|live | brkp_r);
	assign acc   = avs_read | avs_write;
	assign wr_hit = avs_write & ack_r;
	assign rd_hit = avs_read & ~ack_r;
	assign hw_clr = (st_r == MIC_CLR_F && src_r != `MIC_SRC_BRK) ?
		9'(9'h1 << src_r) : 9'h0;

	// One wait state, answer on the second edge
	assign avs_waitrequest = acc & ~ack_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= acc & ~ack_r;
		end
	end

	// Request flags: hardware set wins over software or accept clear
	logic [8:0] req_nxt;
	always_comb begin
		req_nxt = req_r & ~hw_clr;
		if (wr_hit && avs_address == `MIC_OFS_REQH) begin
			req_nxt[7:0] = avs_writedata[7:0];
		end
		if (wr_hit && avs_address == `MIC_OFS_REQL) begin
			req_nxt[8] = avs_writedata[0];
		end
		req_nxt = req_nxt | set_v;
	end

	// Registers written by software
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_r  <= 9'h0;
			en_r   <= 9'h0;
			edge_r <= `MIC_RST_BYTE;
		end else begin
			req_r <= req_nxt;
			if (wr_hit && avs_address == `MIC_OFS_ENH) begin
				en_r[7:0] <= avs_writedata[7:0];
			end
			if (wr_hit && avs_address == `MIC_OFS_ENL) begin
				en_r[8] <= avs_writedata[0];
			end
			if (wr_hit && avs_address == `MIC_OFS_EDGE) begin
				edge_r <= avs_writedata[7:0];
			end
		end
	end

	// Read mux; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h0;
		end else if (rd_hit) begin
			case (avs_address)
				`MIC_OFS_ENH:  rdata_r <= {24'h0, en_r[7:0]};
				`MIC_OFS_ENL:  rdata_r <= {31'h0, en_r[8]};
				`MIC_OFS_REQH: rdata_r <= {24'h0, req_r[7:0]};
				`MIC_OFS_REQL: rdata_r <= {31'h0, req_r[8]};
				`MIC_OFS_EDGE: rdata_r <= {24'h0, edge_r};
				`MIC_OFS_STAT: rdata_r <= {24'h0, src_r, 1'b0, st_r};
				`MIC_OFS_CPU:  rdata_r <= {29'h0, brkp_r, brk_r, gie_r};
				default:       rdata_r <= 32'h0;
			endcase
		end
	end
	assign avs_readdata = rdata_r;

	// Acceptance sequence
	always_comb begin
		case (st_r)
			MIC_IDLE:  st_nxt = start ? MIC_CLR_I : MIC_IDLE;
			MIC_CLR_I: st_nxt = MIC_CLR_F;
			MIC_CLR_F: st_nxt = MIC_PUSH;
			MIC_PUSH:  st_nxt = (push_r == `MIC_PUSHES - 2'h1) ? MIC_VEC : MIC_PUSH;
			MIC_VEC:   st_nxt = MIC_WAIT;
			MIC_WAIT:  st_nxt = (cnt_r == `MIC_ACC_CYC - 4'h1) ? MIC_IDLE : MIC_WAIT;
			default:   st_nxt = MIC_IDLE;
		endcase
	end

	// Sequencer registers; eight cycles from start to idle again
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r   <= MIC_IDLE;
			cnt_r  <= 4'h0;
			push_r <= 2'h0;
			src_r  <= `MIC_SRC_BRK;
			vec_r  <= 16'h0;
		end else begin
			st_r  <= st_nxt;
			cnt_r <= (st_r == MIC_IDLE) ? 4'h0 : cnt_r + 4'h1;
			push_r <= (st_r == MIC_PUSH) ? push_r + 2'h1 : 2'h0;
			if (start) begin
				src_r <= win;
			end
			if (st_r == MIC_PUSH && st_nxt == MIC_VEC) begin
				vec_r <= vec_of(src_r);
			end
		end
	end

	// Global enable and break flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gie_r  <= 1'b0;
			brk_r  <= 1'b0;
			brkp_r <= 1'b0;
		end else begin
			if (st_r == MIC_CLR_I) begin
				gie_r <= 1'b0;
			end else if (disable_irq_instr) begin
				gie_r <= 1'b0;
			end else if (enable_irq_instr | return_from_irq) begin
				gie_r <= 1'b1;
			end
			// Break pending held so it waits behind maskable requests
			if (software_break) begin
				brkp_r <= 1'b1;
			end else if (st_r == MIC_CLR_F && src_r == `MIC_SRC_BRK) begin
				brkp_r <= 1'b0;
			end
			if (st_r == MIC_CLR_F) begin
				brk_r <= (src_r == `MIC_SRC_BRK);
			end else if (return_from_irq) begin
				brk_r <= 1'b0;
			end
		end
	end

	assign acc_busy      = (st_r != MIC_IDLE);
	assign push_strobe   = (st_r == MIC_PUSH);
	assign vector_load   = (st_r == MIC_VEC);
	assign vector_addr   = vec_r;
	assign break_flag    = brk_r;
	assign global_enable = gie_r;

	a_gie_blocks: assert property (@(posedge clk) disable iff (!rst_n)
		start && !gie_r |=> src_r == `MIC_SRC_BRK)
		else $error("maskable accept with global enable clear");
	a_push_three: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(st_r == MIC_PUSH) |-> push_strobe [*3] ##1 vector_load)
		else $error("push count not three");
	a_acc_len: assert property (@(posedge clk) disable iff (!rst_n)
		start |=> acc_busy [*8] ##1 !acc_busy)
		else $error("acceptance not eight cycles");
	a_gie_clear: assert property (@(posedge clk) disable iff (!rst_n)
		start |-> ##2 !gie_r)
		else $error("global enable not cleared");
	a_flag_clear: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == MIC_CLR_F && src_r < 4'h9 && !set_v[src_r] && !wr_hit |=> !req_r[src_r])
		else $error("accepted flag not cleared");
	a_mask_hold: assert property (@(posedge clk) disable iff (!rst_n)
		start && win != `MIC_SRC_BRK |-> en_r[win])
		else $error("disabled source accepted");
	a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		set_v[0] |=> req_r[0])
		else $error("flag set lost");
	a_return_from_irq_gie: assert property (@(posedge clk) disable iff (!rst_n)
		return_from_irq && !disable_irq_instr && st_r != MIC_CLR_I |=> gie_r)
		else $error("return did not set global enable");
	a_prio_top: assert property (@(posedge clk) disable iff (!rst_n)
		start && live[0] |=> src_r == 4'h0)
		else $error("priority not honoured");
	a_brk_flag: assert property (@(posedge clk) disable iff (!rst_n)
		st_r == MIC_CLR_F && src_r == `MIC_SRC_BRK |=> break_flag)
		else $error("break flag not set");
endmodule // mic_intc

// File: bench/mic_cpu_model.sv
// CPU core stand-in: ends instructions on demand, tallies pushes, keeps the fetched vector.
// Assumes the controller's accept strobes change just after rising clk edges.
`timescale 1ns/100ps
module mic_cpu_model (
	input  wire logic        clk,
	input  wire logic        push_strobe,
	input  wire logic        vector_load,
	input  wire logic [15:0] vector_addr,
	output logic             instr_done,
	output logic      [3:0]  push_cnt,
	output logic      [15:0] vec_seen
);
	initial begin
		instr_done = 1'b0;
		push_cnt = 4'h0;
		vec_seen = 16'h0000;
	end
	// Stack pushes and vector fetch as the core sees them
	always @(posedge clk) begin
		if (push_strobe)
			push_cnt <= push_cnt + 4'h1;
		if (vector_load)
			vec_seen <= vector_addr;
	end
	// One-cycle end of instruction; the push tally restarts per acceptance
	task automatic finish_instr();
		@(posedge clk);
		instr_done <= 1'b1;
		push_cnt <= 4'h0;
		@(posedge clk);
		instr_done <= 1'b0;
	endtask
endmodule // mic_cpu_model

// File: bench/testbench.sv
// Self-checking bench: bus tasks, event pulses and acceptance runs.
// Assumes the controller core and the CPU stand-in on one 125 MHz clock.
`timescale 1ns/100ps
`include "mic_consts.svh"
module testbench;
	logic        clk;
	logic        rstn;
	logic [11:0] addr;
	logic        rd;
	logic        wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        waitreq;
	logic [31:0] rdat;
	logic        ext_a;
	logic        ext_b;
	logic [9:0]  ev;
	logic        irq, busy, push, vload, brkf, gie, idone;
	logic [15:0] vaddr;
	logic [3:0]  pcnt;
	logic [15:0] vseen;
	int          err_count = 0;
	int          samples_checked = 0;

	mic_intc uut (.clk(clk), .rstn(rstn), .avs_address(addr), .avs_read(rd),
		.avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
		.avs_waitrequest(waitreq), .external_irq_a(ext_a), .external_irq_b(ext_b),
		.timer0_match(ev[0]), .timer1_match(ev[1]), .conversion_done(ev[2]),
		.watchdog_match(ev[3]), .interval_overflow(ev[4]), .serial_done(ev[5]),
		.instr_done(idone), .disable_irq_instr(ev[6]), .enable_irq_instr(ev[7]),
		.return_from_irq(ev[8]), .software_break(ev[9]), .irq_to_cpu(irq),
		.acc_busy(busy), .push_strobe(push), .vector_load(vload),
		.vector_addr(vaddr), .break_flag(brkf), .global_enable(gie));
	mic_cpu_model cpu (.clk(clk), .push_strobe(push), .vector_load(vload),
		.vector_addr(vaddr), .instr_done(idone), .push_cnt(pcnt), .vec_seen(vseen));

	// 8 ns clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Avalon request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic [11:0] a, input logic w, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		addr <= a;
		rd <= ~w;
		wr <= w;
		wdata <= {24'h000000, d};
		do @(posedge clk); while (waitreq !== 1'b0 && ++n < 50);
		rdat = rdata;
		if (n >= 50)
			chk(1'b0, 1'b1, "bus answer");
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		bus(a, 1'b0, 8'h00);
		chk(rdat, {24'h000000, e}, "register read");
	endtask

	task automatic pulse(input logic [9:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 10'h000;
		// Let registered outputs settle before any check
		@(negedge clk);
	endtask

	// Busy span, pushes, vector and cleared global enable of one acceptance
	task automatic accept(input logic [15:0] v);
		int n;
		n = 0;
		cpu.finish_instr();
		@(negedge clk);
		while (busy === 1'b1 && n < 20) begin
			n++;
			@(negedge clk);
		end
		chk(n, 8, "accept cycles");
		chk(pcnt, 4'h3, "push count");
		chk(vseen, v, "vector");
		chk(gie, 1'b0, "gie after accept");
	endtask

	// Pins settle over a few machine cycles of four clocks
	// Pins taken as routed to the controller by port function select
	task automatic pins(input logic a, input logic b);
		@(posedge clk);
		ext_a <= a;
		ext_b <= b;
		repeat (16) @(posedge clk);
	endtask

	initial begin
		rstn = 1'b0;
		addr = 12'h000;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h00000000;
		ext_a = 1'b0;
		ext_b = 1'b0;
		ev = 10'h000;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		rc(`MIC_OFS_ENH, 8'h00);
		rc(`MIC_OFS_ENL, 8'h00);
		rc(`MIC_OFS_REQH, 8'h00);
		rc(`MIC_OFS_REQL, 8'h00);
		rc(`MIC_OFS_EDGE, 8'h00);
		rc(12'h0a0, 8'h00); // Unmapped reads zero
		bus(`MIC_OFS_ENH, 1'b1, 8'hff);
		rc(`MIC_OFS_ENH, 8'hff);
		$display("test reset and access done");
		// Flag set but global enable clear: nothing reaches the core
		pulse(10'h001);
		rc(`MIC_OFS_REQH, 8'h04);
		chk(irq, 1'b0, "irq with gie 0");
		cpu.finish_instr();
		repeat (3) @(negedge clk);
		chk(busy, 1'b0, "refused accept");
		pulse(10'h080);
		chk(gie, 1'b1, "enable instr");
		chk(irq, 1'b1, "irq gated on");
		bus(`MIC_OFS_ENH, 1'b1, 8'hfb);
		@(negedge clk);
		chk(irq, 1'b0, "disabled source");
		rc(`MIC_OFS_REQH, 8'h04);
		bus(`MIC_OFS_ENH, 1'b1, 8'hff);
		$display("test gating done");
		// Three pending at once leave in priority order
		pulse(10'h006);
		accept(`MIC_VEC_BASE + 16'h0004);
		rc(`MIC_OFS_REQH, 8'h18);
		pulse(10'h100);
		chk(gie, 1'b1, "return sets gie");
		accept(`MIC_VEC_BASE + 16'h0006);
		pulse(10'h100);
		accept(`MIC_VEC_BASE + 16'h0008);
		pulse(10'h100);
		// Each internal source alone, with its own vector
		for (int i = 0; i < 6; i++) begin
			pulse(10'h001 << i);
			accept(`MIC_VEC_BASE + 16'(2 * (i + 2)));
			pulse(10'h100);
		end
		// Software clear of pending flags
		pulse(10'h038);
		bus(`MIC_OFS_REQH, 1'b1, 8'h00);
		rc(`MIC_OFS_REQH, 8'h00);
		$display("test priority done");
		// External a on rising, b on falling edges
		bus(`MIC_OFS_EDGE, 1'b1, 8'h09);
		pins(1'b1, 1'b1);
		rc(`MIC_OFS_REQH, 8'h01);
		pins(1'b1, 1'b0);
		rc(`MIC_OFS_REQH, 8'h03);
		accept(`MIC_VEC_BASE);
		rc(`MIC_OFS_REQH, 8'h02);
		pulse(10'h100);
		accept(`MIC_VEC_BASE + 16'h0002);
		rc(`MIC_OFS_REQH, 8'h00);
		// Both-edge mode on pin a
		bus(`MIC_OFS_EDGE, 1'b1, 8'h03);
		pins(1'b0, 1'b0);
		rc(`MIC_OFS_REQH, 8'h01);
		bus(`MIC_OFS_REQH, 1'b1, 8'h00);
		pins(1'b1, 1'b0);
		rc(`MIC_OFS_REQH, 8'h01);
		bus(`MIC_OFS_REQH, 1'b1, 8'h00);
		$display("test external done");
		// Nesting: service routine re-enables and admits only timer 0
		pulse(10'h100);
		pulse(10'h004);
		accept(`MIC_VEC_BASE + 16'h0008);
		bus(`MIC_OFS_ENH, 1'b1, 8'h04);
		pulse(10'h003);
		chk(irq, 1'b0, "nested before enable");
		pulse(10'h080);
		accept(`MIC_VEC_BASE + 16'h0004);
		rc(`MIC_OFS_REQH, 8'h08);
		bus(`MIC_OFS_REQH, 1'b1, 8'h00);
		bus(`MIC_OFS_ENH, 1'b1, 8'hff);
		pulse(10'h100);
		chk(gie, 1'b1, "inner return");
		$display("test nesting done");
		// Break still taken with global enable cleared
		pulse(10'h040);
		chk(gie, 1'b0, "disable instr");
		pulse(10'h200);
		accept(`MIC_VEC_BRK);
		chk(brkf, 1'b1, "break flag");
		rc(`MIC_OFS_CPU, 8'h02);
		rc(`MIC_OFS_STAT, 8'h90);
		$display("test break done");
		tally_and_finish();
	end

	// Hang guard well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end
endmodule // testbench
